//--- uart_autobaud_pkg.sv
// constants, state codes and rate masks for the auto-baud receiver front end
//
// What this block does
// - receive line times divisor counter over 55h
// - enabling auto-baud starts sequence, receiver held idle
// - counting starts at first rise after start
// - fifth rise: keep count, clear enable, raise flag
// - reading receive data clears receive flag
// - both divisor bytes form one 16-bit counter
// - measuring counter runs at one eighth base rate
// - rate selects pick base and auto-baud clocks
// - counter starts at one; software subtracts one
// - with wake enabled, measure character after break
// - counter wrap before fifth rise sets overflow
// - after overflow keep counting until fifth rise
// - software clears overflow flag directly
// - overflow clear ignored while enable still set
// - wake enable: falling edge raises receive flag
package uart_autobaud_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // measurement constants
    localparam logic [7:0]  SYNC_CHAR      = 8'h55;  // character being timed
    localparam logic [15:0] COUNT_START    = 16'h0001;
    localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
    localparam logic [2:0]  EDGE_FIRST     = 3'h1;
    localparam logic [2:0]  EDGE_BEFORE_LAST = 3'h4;  // fifth rise follows this count
    localparam logic [7:0]  DIVISOR_RESET  = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // prescaler masks: tick when the masked prescaler bits are all ones
    localparam int          PRESCALE_W     = 9;
    localparam logic [8:0]  BASE_MASK_FAST = 9'h003;  // oscillator / 4
    localparam logic [8:0]  BASE_MASK_MID  = 9'h00F;  // oscillator / 16
    localparam logic [8:0]  BASE_MASK_SLOW = 9'h03F;  // oscillator / 64
    localparam logic [8:0]  MEAS_MASK_FAST = 9'h01F;  // oscillator / 32
    localparam logic [8:0]  MEAS_MASK_MID  = 9'h07F;  // oscillator / 128
    localparam logic [8:0]  MEAS_MASK_SLOW = 9'h1FF;  // oscillator / 512
    localparam logic [1:0]  RATE_BOTH      = 2'h3;
    localparam logic [1:0]  RATE_NONE      = 2'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // receiver states, gray along start -> first rise -> counting
    typedef enum logic [2:0] {
        ST_IDLE       = 3'h0,
        ST_MEAS_START = 3'h1,
        ST_MEAS_FIRST = 3'h3,
        ST_MEAS_COUNT = 3'h2,
        ST_WAKE_ARMED = 3'h4,
        ST_WAKE_LOW   = 3'h5
    } rx_state_t;

endpackage

//--- rate_divider.sv
// prescaler giving base and auto-baud tick enables from the system clock
module rate_divider
    import uart_autobaud_pkg::*;
(
    input  wire logic mclk,
    input  wire logic arst_n,
    input  wire logic wide_sel,
    input  wire logic high_sel,
    output logic      base_tick,
    output logic      meas_tick
);

    typedef struct packed {
        logic [8:0] cnt;
        logic       base_tick;
        logic       meas_tick;
    } div_state_t;

    div_state_t d_r;
    div_state_t d_nxt;
    logic [8:0] base_mask;
    logic [8:0] meas_mask;
    logic [1:0] sel;

    assign sel = {wide_sel, high_sel};

    ////////////////////////////////////////////////////////////////////////////////
    // mask choice
    always_comb begin
        unique case (sel)
            RATE_BOTH: begin
                base_mask = BASE_MASK_FAST;
                meas_mask = MEAS_MASK_FAST;
            end
            RATE_NONE: begin
                base_mask = BASE_MASK_SLOW;
                meas_mask = MEAS_MASK_SLOW;
            end
            default: begin
                base_mask = BASE_MASK_MID;
                meas_mask = MEAS_MASK_MID;
            end
        endcase
    end

    // free-running count; measuring mask is base mask plus three bits, hence 1/8
    always_comb begin
        d_nxt           = d_r;
        d_nxt.cnt       = d_r.cnt + 9'h001;
        d_nxt.base_tick = ((d_r.cnt & base_mask) == base_mask);
        d_nxt.meas_tick = ((d_r.cnt & meas_mask) == meas_mask);
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            d_r <= '0;
        end else begin
            d_r <= d_nxt;
        end
    end

    assign base_tick = d_r.base_tick;
    assign meas_tick = d_r.meas_tick;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    chk_meas_subset: assert property (@(posedge mclk) disable iff (!arst_n)
        meas_tick |-> base_tick) else $error("auto-baud tick without base tick");

    // the first tick after reset has no earlier tick to look back to
    chk_fast_period: assert property (@(posedge mclk) disable iff (!arst_n)
        (base_tick && $past(sel) == RATE_BOTH && $past(sel, 5) == RATE_BOTH
        && $past(arst_n, 5)) |-> $past(base_tick, 4))
        else $error("fast base tick period not four");

endmodule

//--- uart_autobaud_detect.sv
// auto-baud measurement, overflow and wake handling around the baud generator
module uart_autobaud_detect
    import uart_autobaud_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic       receive_line,
    input  wire logic       wide_divisor_select,
    input  wire logic       high_speed_select,
    input  wire logic       autobaud_enable_set,
    input  wire logic       autobaud_enable_clr,
    input  wire logic       wake_on_break_enable_set,
    input  wire logic       wake_on_break_enable_clr,
    input  wire logic       overflow_clr,
    input  wire logic       receive_data_rd,
    input  wire logic       divisor_low_wr,
    input  wire logic       divisor_high_wr,
    input  wire logic [7:0] divisor_wdata,
    output logic            autobaud_enable,
    output logic            autobaud_mode,
    output logic            autobaud_overflow_flag,
    output logic            wake_on_break_enable,
    output logic            receive_flag,
    output logic [7:0]      divisor_low_byte,
    output logic [7:0]      divisor_high_byte,
    output logic            bit_tick
);

    typedef struct packed {
        logic       rx_meta;
        logic       rx_sync;
        logic       rx_prev;
        rx_state_t  st;
        logic [2:0] edge_cnt;
        logic [7:0] div_lo;
        logic [7:0] div_hi;
        logic [15:0] baud_cnt;
        logic       meas_en;
        logic       ovf;
        logic       wake_en;
        logic       rcv_flag;
        logic       bit_tick;
        logic       meas_mode;
    } core_state_t;

    core_state_t s_r;
    core_state_t s_nxt;
    logic        base_tick;
    logic        meas_tick;
    logic        rx_rise;
    logic        rx_fall;
    logic        counting;
    logic        fifth_rise;
    logic        meas_done;
    logic        ovf_wrap;
    logic        wake_fall;
    logic        wake_end;
    logic        flag_set;
    logic [15:0] pair;
    logic [15:0] reload;
    logic        gen_run;

    ////////////////////////////////////////////////////////////////////////////////
    // prescaler
    rate_divider u_div (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .wide_sel  (wide_divisor_select),
        .high_sel  (high_speed_select),
        .base_tick (base_tick),
        .meas_tick (meas_tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // edge and event decode, all from synchronised samples
    assign rx_rise    = s_r.rx_sync & ~s_r.rx_prev;
    assign rx_fall    = ~s_r.rx_sync & s_r.rx_prev;
    assign counting   = (s_r.st == ST_MEAS_COUNT) && s_r.meas_en;
    assign pair       = {s_r.div_hi, s_r.div_lo};
    assign fifth_rise = counting && rx_rise && (s_r.edge_cnt == EDGE_BEFORE_LAST);
    assign meas_done  = fifth_rise;
    assign ovf_wrap   = counting && meas_tick && (pair == COUNT_MAX);
    assign wake_fall  = (s_r.st == ST_WAKE_ARMED) && s_r.wake_en && rx_fall;
    assign wake_end   = (s_r.st == ST_WAKE_LOW) && rx_rise;
    assign flag_set   = meas_done || wake_fall;
    // low byte only unless the wide divisor is chosen
    assign reload     = wide_divisor_select ? pair : {8'h00, s_r.div_lo};
    // generator stopped while auto-baud or wake owns the receiver
    assign gen_run    = (s_r.st == ST_IDLE) && !s_r.meas_en && !s_r.wake_en;

    ////////////////////////////////////////////////////////////////////////////////
    // next-state logic for the whole block
    always_comb begin
        s_nxt          = s_r;
        s_nxt.rx_meta  = receive_line;
        s_nxt.rx_sync  = s_r.rx_meta;
        s_nxt.rx_prev  = s_r.rx_sync;
        s_nxt.bit_tick = 1'b0;

        // enable bit: hardware clear on completion, software set wins
        if (autobaud_enable_clr) begin
            s_nxt.meas_en = 1'b0;
        end
        if (meas_done) begin
            s_nxt.meas_en = 1'b0;
        end
        if (autobaud_enable_set) begin
            s_nxt.meas_en = 1'b1;
        end

        // wake enable: cleared by the rise ending the break
        if (wake_on_break_enable_clr || wake_end) begin
            s_nxt.wake_en = 1'b0;
        end
        if (wake_on_break_enable_set) begin
            s_nxt.wake_en = 1'b1;
        end

        // clear blocked while enable is set
        if (overflow_clr && !s_r.meas_en) begin
            s_nxt.ovf = 1'b0;
        end
        if (ovf_wrap) begin
            s_nxt.ovf = 1'b1;
        end

        if (receive_data_rd) begin
            s_nxt.rcv_flag = 1'b0;
        end
        if (flag_set) begin
            s_nxt.rcv_flag = 1'b1;
        end

        // software divisor writes only land when nothing is measuring
        if (s_r.st == ST_IDLE && !s_r.meas_en) begin
            if (divisor_low_wr) begin
                s_nxt.div_lo = divisor_wdata;
            end
            if (divisor_high_wr) begin
                s_nxt.div_hi = divisor_wdata;
            end
        end

        unique case (s_r.st)
            ST_IDLE: begin
                if (s_r.wake_en) begin
                    s_nxt.st = ST_WAKE_ARMED;
                end else if (s_r.meas_en) begin
                    s_nxt.st = ST_MEAS_START;
                end
            end
            ST_MEAS_START: begin
                // start bit of the sync character
                if (!s_r.meas_en) begin
                    s_nxt.st = ST_IDLE;
                end else if (rx_fall) begin
                    s_nxt.st = ST_MEAS_FIRST;
                end
            end
            ST_MEAS_FIRST: begin
                if (!s_r.meas_en) begin
                    s_nxt.st = ST_IDLE;
                end else if (rx_rise) begin
                    {s_nxt.div_hi, s_nxt.div_lo} = COUNT_START;
                    s_nxt.edge_cnt = EDGE_FIRST;
                    s_nxt.st       = ST_MEAS_COUNT;
                end
            end
            ST_MEAS_COUNT: begin
                if (!s_r.meas_en) begin
                    // aborted; pair keeps the partial count
                    s_nxt.st = ST_IDLE;
                end else begin
                    // wraps to zero, sets overflow and keeps counting after overflow
                    if (meas_tick) begin
                        {s_nxt.div_hi, s_nxt.div_lo} = pair + 16'h0001;
                    end
                    if (rx_rise) begin
                        s_nxt.edge_cnt = s_r.edge_cnt + 3'h1;
                    end
                    if (fifth_rise) begin
                        s_nxt.st = ST_IDLE;
                    end
                end
            end
            ST_WAKE_ARMED: begin
                // falling edge is the wake event
                if (!s_r.wake_en) begin
                    s_nxt.st = ST_IDLE;
                end else if (rx_fall) begin
                    s_nxt.st = ST_WAKE_LOW;
                end
            end
            ST_WAKE_LOW: begin
                if (rx_rise || !s_r.wake_en) begin
                    s_nxt.st = ST_IDLE;
                end
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase

        if (!gen_run) begin
            s_nxt.baud_cnt = reload;
        end else if (base_tick) begin
            if (s_r.baud_cnt == 16'h0000) begin
                s_nxt.baud_cnt = reload;
                s_nxt.bit_tick = 1'b1;
            end else begin
                s_nxt.baud_cnt = s_r.baud_cnt - 16'h0001;
            end
        end

        s_nxt.meas_mode = (s_nxt.st == ST_MEAS_START) || (s_nxt.st == ST_MEAS_FIRST)
                        || (s_nxt.st == ST_MEAS_COUNT);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_r        <= '0;
            s_r.st     <= ST_IDLE;
            // line idles high, so no false edge follows reset
            s_r.rx_meta <= 1'b1;
            s_r.rx_sync <= 1'b1;
            s_r.rx_prev <= 1'b1;
            s_r.div_lo <= DIVISOR_RESET;
            s_r.div_hi <= DIVISOR_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state flops
    assign autobaud_enable        = s_r.meas_en;
    assign autobaud_mode          = s_r.meas_mode;
    assign autobaud_overflow_flag = s_r.ovf;
    assign wake_on_break_enable   = s_r.wake_en;
    assign receive_flag           = s_r.rcv_flag;
    assign divisor_low_byte       = s_r.div_lo;
    assign divisor_high_byte      = s_r.div_hi;
    assign bit_tick               = s_r.bit_tick;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    chk_held_idle: assert property (
        s_r.meas_en |=> !s_r.bit_tick) else $error("bit tick during auto-baud");

    chk_count_one: assert property (
        (s_r.st == ST_MEAS_FIRST && s_r.meas_en && rx_rise) |=> (pair == COUNT_START))
        else $error("counter did not start at one");

    chk_count_step: assert property (
        (counting && meas_tick) |=> (pair == $past(pair) + 16'h0001))
        else $error("counter missed an auto-baud tick");

    chk_count_hold: assert property (
        (counting && !meas_tick) |=> (pair == $past(pair)))
        else $error("counter moved without a tick");

    chk_done_flags: assert property (
        (fifth_rise && !autobaud_enable_set) |=> (!s_r.meas_en && s_r.rcv_flag
        && s_r.st == ST_IDLE)) else $error("completion flags wrong");

    chk_ovf_set: assert property (
        ovf_wrap |=> (s_r.ovf && pair == 16'h0000)) else $error("overflow not flagged");

    chk_ovf_continue: assert property (
        (ovf_wrap && !fifth_rise && !autobaud_enable_clr) |=> (s_r.st == ST_MEAS_COUNT))
        else $error("counting stopped after overflow");

    chk_ovf_hold: assert property (
        (s_r.ovf && s_r.meas_en) |=> s_r.ovf) else $error("overflow cleared while enabled");

    chk_ovf_clear: assert property (
        (s_r.ovf && !s_r.meas_en && overflow_clr) |=> !s_r.ovf)
        else $error("overflow clear ignored");

    chk_read_clear: assert property (
        (receive_data_rd && !flag_set) |=> !s_r.rcv_flag) else $error("read did not clear flag");

    chk_wake_flag: assert property (
        wake_fall |=> (s_r.rcv_flag && s_r.st == ST_WAKE_LOW)) else $error("wake event lost");

    chk_break_first: assert property (
        (s_r.wake_en && s_r.st == ST_IDLE) |=> (s_r.st != ST_MEAS_START))
        else $error("measured during break");

    cov_meas_done: cover property (fifth_rise);
    cov_meas_ovf: cover property (ovf_wrap ##[1:1000] fifth_rise);
    cov_wake_then_meas: cover property (wake_end ##[1:1000] (s_r.st == ST_MEAS_FIRST));
    cov_abort: cover property (counting && autobaud_enable_clr);

endmodule

//--- remote_node.sv
// behavioural remote serial node driving the receive line
module remote_node (
    input  wire logic mclk,
    output logic      receive_line
);
    timeunit 1ns;
    timeprecision 100ps;

    // line idles high between characters
    initial receive_line = 1'b1;

    // hold a level for n clock cycles, changing just after an edge
    task automatic hold(input logic v, input int n);
        @(posedge mclk);
        #1 receive_line = v;
        repeat (n - 1) @(posedge mclk);
    endtask

    // framed character, start bit, lsb first, one stop bit
    task automatic send_char(input logic [7:0] d, input int bl);
        hold(1'b0, bl);
        for (int i = 0; i < 8; i++) begin
            hold(d[i], bl);
        end
        hold(1'b1, bl);
    endtask

    // break of thirteen low bit times, then one idle bit
    task automatic send_break(input int bl);
        hold(1'b0, 13 * bl);
        hold(1'b1, bl);
    endtask
endmodule

//--- uart_autobaud_detect_tb.sv
// self-checking bench for the auto-baud receiver front end
module uart_autobaud_detect_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import uart_autobaud_pkg::*;

    localparam logic [5:0] EN_SET = 6'h01;
    localparam logic [5:0] EN_CLR = 6'h02;
    localparam logic [5:0] WK_SET = 6'h04;
    localparam logic [5:0] WK_CLR = 6'h08;
    localparam logic [5:0] OV_CLR = 6'h10;
    localparam logic [5:0] RD     = 6'h20;

    logic       mclk;
    logic       arst_n;
    logic       rx;
    logic       wide;
    logic       high;
    logic [5:0] ctl;
    logic       low_wr;
    logic       high_wr;
    logic [7:0] wdata;
    logic       en;
    logic       mode;
    logic       ovf;
    logic       wake;
    logic       flag;
    logic [7:0] lo;
    logic [7:0] hi;
    logic       tick;
    int         n_errors;
    int         checked;

    uart_autobaud_detect dut (
        .mclk(mclk), .arst_n(arst_n), .receive_line(rx),
        .wide_divisor_select(wide), .high_speed_select(high),
        .autobaud_enable_set(ctl[0]), .autobaud_enable_clr(ctl[1]),
        .wake_on_break_enable_set(ctl[2]), .wake_on_break_enable_clr(ctl[3]),
        .overflow_clr(ctl[4]), .receive_data_rd(ctl[5]),
        .divisor_low_wr(low_wr), .divisor_high_wr(high_wr), .divisor_wdata(wdata),
        .autobaud_enable(en), .autobaud_mode(mode), .autobaud_overflow_flag(ovf),
        .wake_on_break_enable(wake), .receive_flag(flag),
        .divisor_low_byte(lo), .divisor_high_byte(hi), .bit_tick(tick)
    );

    remote_node node (.mclk(mclk), .receive_line(rx));

    // free-running clock at 125 MHz
    always #4 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////////
    // verdict and closing report
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic fail(input logic [15:0] got, input logic [15:0] exp);
        n_errors++;
        $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) fail(got, exp);
    endtask

    // tick phase is free running, so allow one count either way
    task automatic near(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp && got !== exp - 16'h1 && got !== exp + 16'h1) fail(got, exp);
    endtask

    task automatic step;
        @(posedge mclk);
        #1;
    endtask

    // one-cycle control pulse, at least one idle cycle before the next
    task automatic strobe(input logic [5:0] m);
        step();
        ctl = m;
        step();
        ctl = 6'h00;
    endtask

    task automatic wr_div(input logic sel_hi, input logic [7:0] d);
        step();
        wdata = d;
        low_wr = ~sel_hi;
        high_wr = sel_hi;
        step();
        low_wr = 1'b0;
        high_wr = 1'b0;
    endtask

    task automatic wait_flag;
        int i;
        i = 0;
        // leave the edge on which the caller returned
        step();
        while (flag !== 1'b1 && i < 100) begin
            step();
            i++;
        end
        if (i >= 100) begin
            fail({15'h0, flag}, 16'h1);
            stop_test();
        end
    endtask

    // full calibration on one 55h character
    task automatic measure(input logic w, input logic h, input int bl, input int dv);
        logic [15:0] exp;
        exp = 16'(1 + (8 * bl) / dv);
        step();
        wide = w;
        high = h;
        strobe(EN_SET);
        chk({15'h0, en}, 16'h1);                            // enable taken
        step();
        chk({15'h0, mode}, 16'h1);                          // measuring
        node.send_char(SYNC_CHAR, bl);                      // sync char
        wait_flag();
        chk({15'h0, en}, 16'h0);                            // enable auto clear
        chk({15'h0, mode}, 16'h0);                          // back to idle
        chk({15'h0, ovf}, 16'h0);                           // no wrap
        near({hi, lo}, exp);                                // count
        if (exp < 16'h0100) chk({8'h00, hi}, 16'h0000);     // high byte zero
        strobe(RD);
        chk({15'h0, flag}, 16'h0);                          // read clears flag
        $display("test measure %0d done", dv);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        int n;
        mclk = 1'b0;
        arst_n = 1'b0;
        wide = 1'b1;
        high = 1'b1;
        ctl = 6'h00;
        low_wr = 1'b0;
        high_wr = 1'b0;
        wdata = 8'h00;
        n_errors = 0;
        checked = 0;
        repeat (6) @(posedge mclk);
        #1 arst_n = 1'b1;
        chk({11'h000, en, mode, ovf, wake, flag}, 16'h0000);
        chk({hi, lo}, 16'h0000);
        $display("test reset done");

        // generator: divisor 3 at base rate /4 gives 16 cycles a bit
        wr_div(1'b1, 8'h00);
        wr_div(1'b0, 8'h03);
        // let any period loaded from the old divisor run out first
        repeat (20) step();
        n = 0;
        while (tick !== 1'b1 && n < 100) begin
            step();
            n++;
        end
        if (n >= 100) fail(16'(n), 16'h0010);               // no tick at all
        n = 0;
        do begin
            step();
            n++;
        end while (tick !== 1'b1 && n < 100);
        chk(16'(n), 16'h0010);                              // bit period
        $display("test generator done");

        measure(1'b1, 1'b1, 128, 32);                       // both set
        measure(1'b1, 1'b0, 256, 128);                      // one set
        measure(1'b0, 1'b0, 512, 512);                      // none set
        measure(1'b0, 1'b1, 4096, 128);                     // count above 255

        // abort mid-character: clear enable, then overflow
        step();
        wide = 1'b1;
        high = 1'b1;
        strobe(EN_SET);
        fork
            node.send_char(SYNC_CHAR, 128);
        join_none
        repeat (600) step();
        strobe(EN_CLR);                                     // enable first
        step();
        chk({14'h0, en, mode}, 16'h0);                      // aborted
        strobe(OV_CLR);                                     // then overflow
        chk({15'h0, ovf}, 16'h0);                           // flag clear
        repeat (800) step();
        chk({15'h0, flag}, 16'h0);                          // no completion
        $display("test abort done");

        // wake on break then measure the following character
        strobe(WK_SET);
        strobe(WK_CLR);
        chk({15'h0, wake}, 16'h0);                          // wake disarmed
        strobe(WK_SET);
        chk({15'h0, wake}, 16'h1);                          // wake armed
        strobe(EN_SET);
        fork
            node.send_break(128);                           // break first
        join_none
        repeat (40) step();
        chk({14'h0, flag, wake}, 16'h3);                    // fall raises flag
        strobe(RD);
        chk({15'h0, flag}, 16'h0);                          // read clears flag
        repeat (1800) step();
        chk({14'h0, wake, en}, 16'h1);                      // rise ends wake
        node.send_char(SYNC_CHAR, 128);
        wait_flag();
        near({hi, lo}, 16'h0021);                           // char after break
        chk({15'h0, en}, 16'h0);                            // enable auto clear
        $display("test wake done");
        stop_test();
    end
endmodule
